// file: lbc_counter.sv
// Purpose: One limited up/down counting channel with compare output.
// Assumes: 10 MHz CLK, SRST synchronous active high, AXI4-Lite slave.
// Notes:   Software keeps limits, start and compare values consistent.
module lbc_counter #(
  parameter bit SIGNED_RANGE = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        CNT_IN,
  input  wire logic        AUX_IN,
  output logic             CMP_OUT,
  output logic             IRQ,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  // Elaboration check on the variant switch
  if (SIGNED_RANGE !== 1'b0 && SIGNED_RANGE !== 1'b1) begin : g_chk
    $error("SIGNED_RANGE must be 0 or 1");
  end

  localparam logic [31:0] HIGH_RST =
    SIGNED_RANGE ? lbc_pkg::HIGH_RST_S : lbc_pkg::HIGH_RST_U;
  localparam logic [31:0] CMP_RST =
    SIGNED_RANGE ? lbc_pkg::CMP_RST_S : lbc_pkg::CMP_RST_U;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        have_aw;
    logic        have_w;
    logic [7:0]  aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [31:0] ctrl;
    logic [31:0] low;
    logic [31:0] high;
    logic [31:0] start;
    logic [31:0] cmp;
    logic [31:0] cmp0;
    logic [31:0] cmp1;
    logic [31:0] count;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        stopped;
    logic        gate;
    logic        cmp_bit;
    logic        irq;
  } lbc_state_t;

  lbc_state_t s_q;
  lbc_state_t s_d;

  logic cnt_lvl;
  logic cnt_rise;
  logic cnt_fall;
  logic aux_lvl;
  logic aux_rise;
  logic aux_fall;

  // Both pins cross into CLK through two flops
  lbc_sync u_sync_cnt (
    .clk  (CLK),
    .srst (SRST),
    .din  (CNT_IN),
    .lvl  (cnt_lvl),
    .rise (cnt_rise),
    .fall (cnt_fall)
  );

  lbc_sync u_sync_aux (
    .clk  (CLK),
    .srst (SRST),
    .din  (AUX_IN),
    .lvl  (aux_lvl),
    .rise (aux_rise),
    .fall (aux_fall)
  );

  // Ordering in the chosen range interpretation
  function automatic logic le(input logic [31:0] a, input logic [31:0] b);
    if (SIGNED_RANGE) begin
      le = $signed(a) <= $signed(b);
    end else begin
      le = a <= b;
    end
  endfunction

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = dat[8*i +: 8];
      end
    end
  endfunction

  lbc_pkg::lbc_edge_t edge_sel;
  lbc_pkg::lbc_fn_t   fn_sel;
  lbc_pkg::lbc_di_t   di_sel;
  logic               hw_mode;
  logic               gate_open;
  logic               edge_hit;
  logic               down;
  logic               cnt_ev;
  logic               wr_fire;
  logic               start_wr;
  logic               cmp_next;

  // Decoded control fields and gate
  always_comb begin
    edge_sel = lbc_pkg::lbc_edge_t'(s_q.ctrl[lbc_pkg::CTRL_EDGE_LS +: 2]);
    fn_sel   = lbc_pkg::lbc_fn_t'(s_q.ctrl[lbc_pkg::CTRL_FN_LS +: 3]);
    di_sel   = lbc_pkg::lbc_di_t'(s_q.ctrl[lbc_pkg::CTRL_DI_LS +: 2]);
    hw_mode  = di_sel == lbc_pkg::DI_GATE;
    // software gate qualifies the hardware gate
    gate_open = s_q.ctrl[lbc_pkg::CTRL_SWGATE] & (~hw_mode | aux_lvl);
    case (edge_sel)
      lbc_pkg::EDGE_RISE: edge_hit = cnt_rise;
      lbc_pkg::EDGE_FALL: edge_hit = cnt_fall;
      lbc_pkg::EDGE_BOTH: edge_hit = cnt_rise | cnt_fall;
      default:            edge_hit = cnt_rise;
    endcase
    if (di_sel == lbc_pkg::DI_DIR) begin
      down = aux_lvl;
    end else begin
      down = s_q.ctrl[lbc_pkg::CTRL_DOWN];
    end
    cnt_ev   = edge_hit & gate_open & ~s_q.stopped;
    wr_fire  = s_q.have_aw & s_q.have_w & ~s_q.bvalid;
    start_wr = wr_fire & (s_q.aw_addr == lbc_pkg::OFS_START);
  end

  // compare output from count and compare values
  always_comb begin
    case (fn_sel)
      lbc_pkg::FN_OFF0:   cmp_next = 1'b0;
      lbc_pkg::FN_OFF1:   cmp_next = 1'b1;
      // window between values 0 and 1
      lbc_pkg::FN_INSIDE: cmp_next = le(s_q.cmp0, s_q.count)
                                     & le(s_q.count, s_q.cmp1);
      lbc_pkg::FN_OUTSID: cmp_next = ~(le(s_q.cmp0, s_q.count)
                                     & le(s_q.count, s_q.cmp1));
      lbc_pkg::FN_TO_HI:  cmp_next = le(s_q.cmp, s_q.count)
                                     & le(s_q.count, s_q.high);
      lbc_pkg::FN_TO_LO:  cmp_next = le(s_q.low, s_q.count)
                                     & le(s_q.count, s_q.cmp);
      default:            cmp_next = 1'b0;
    endcase
  end

  logic [1:0]  st_set;
  logic [1:0]  st_clr;
  logic [31:0] rd_val;
  logic        rd_ok;

  // Read multiplexer; unmapped reads return zero and an error
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    case (ARADDR)
      lbc_pkg::OFS_CTRL:   rd_val = s_q.ctrl;
      lbc_pkg::OFS_LOW:    rd_val = s_q.low;
      lbc_pkg::OFS_HIGH:   rd_val = s_q.high;
      lbc_pkg::OFS_START:  rd_val = s_q.start;
      lbc_pkg::OFS_CMP:    rd_val = s_q.cmp;
      lbc_pkg::OFS_CMP0:   rd_val = s_q.cmp0;
      lbc_pkg::OFS_CMP1:   rd_val = s_q.cmp1;
      lbc_pkg::OFS_COUNT:  rd_val = s_q.count;
      lbc_pkg::OFS_STATUS: rd_val = {30'h00000000, s_q.status};
      lbc_pkg::OFS_MASK:   rd_val = {30'h00000000, s_q.mask};
      default:             rd_ok  = 1'b0;
    endcase
  end

  // Next state: bus slave, counting, compare and interrupt
  always_comb begin
    s_d    = s_q;
    st_set = 2'h0;
    st_clr = 2'h0;
    // Address and data taken independently
    if (s_q.awready && AWVALID) begin
      s_d.have_aw = 1'b1;
      s_d.aw_addr = AWADDR;
    end
    if (s_q.wready && WVALID) begin
      s_d.have_w = 1'b1;
      s_d.wdata  = WDATA;
      s_d.wstrb  = WSTRB;
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.have_aw = 1'b0;
      s_d.have_w  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = lbc_pkg::RESP_OKAY;
      case (s_q.aw_addr)
        lbc_pkg::OFS_CTRL: s_d.ctrl = merge(s_q.ctrl, s_q.wdata, s_q.wstrb)
                                      & lbc_pkg::CTRL_MASK;
        lbc_pkg::OFS_LOW: begin
          // unsigned variant keeps low limit at zero
          if (SIGNED_RANGE) begin
            s_d.low = merge(s_q.low, s_q.wdata, s_q.wstrb);
          end
        end
        lbc_pkg::OFS_HIGH:  s_d.high  = merge(s_q.high, s_q.wdata, s_q.wstrb);
        lbc_pkg::OFS_START: s_d.start = merge(s_q.start, s_q.wdata,
                                              s_q.wstrb);
        lbc_pkg::OFS_CMP:   s_d.cmp   = merge(s_q.cmp, s_q.wdata, s_q.wstrb);
        lbc_pkg::OFS_CMP0:  s_d.cmp0  = merge(s_q.cmp0, s_q.wdata, s_q.wstrb);
        lbc_pkg::OFS_CMP1:  s_d.cmp1  = merge(s_q.cmp1, s_q.wdata, s_q.wstrb);
        lbc_pkg::OFS_MASK:  s_d.mask  = s_q.wstrb[0] ? s_q.wdata[1:0]
                                                     : s_q.mask;
        lbc_pkg::OFS_COUNT: s_d.bresp = lbc_pkg::RESP_SLVERR;
        lbc_pkg::OFS_STATUS: s_d.bresp = lbc_pkg::RESP_SLVERR;
        default:            s_d.bresp = lbc_pkg::RESP_SLVERR;
      endcase
    end
    // Ready only while the holding slot is free
    s_d.awready = ~s_d.have_aw;
    s_d.wready  = ~s_d.have_w;
    // One read at a time; status clears when read
    if (s_q.arready && ARVALID) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = rd_val;
      s_d.rresp   = rd_ok ? lbc_pkg::RESP_OKAY : lbc_pkg::RESP_SLVERR;
      if (ARADDR == lbc_pkg::OFS_STATUS) begin
        st_clr = s_q.status;
      end
    end
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    // Gate tracking; a closed gate releases the automatic stop
    s_d.gate = gate_open;
    if (!gate_open) begin
      s_d.stopped = 1'b0;
    end
    if (start_wr) begin
      s_d.count = merge(s_q.start, s_q.wdata, s_q.wstrb);
    end else if (hw_mode && gate_open && !s_q.gate) begin
      // each hardware gate opening starts a fresh pass
      s_d.count = s_q.start;
    end else if (cnt_ev) begin
      if (!down) begin
        if (s_q.count == s_q.high) begin
          s_d.count = s_q.low;
          st_set[lbc_pkg::ST_LIMIT] = 1'b1;
          // one-time counting loads the low limit past the high limit and stops there
          if (hw_mode || s_q.ctrl[lbc_pkg::CTRL_STOP]) begin
            s_d.stopped = 1'b1;
          end
        end else begin
          s_d.count = s_q.count + 32'h00000001;
        end
      end else begin
        if (s_q.count == s_q.low) begin
          s_d.count = s_q.high;
          st_set[lbc_pkg::ST_LIMIT] = 1'b1;
          if (hw_mode || s_q.ctrl[lbc_pkg::CTRL_STOP]) begin
            s_d.stopped = 1'b1;
          end
        end else begin
          s_d.count = s_q.count - 32'h00000001;
        end
      end
    end

    // Compare bit registered; its rising edge is the compare event
    s_d.cmp_bit = cmp_next;
    if (cmp_next && !s_q.cmp_bit) begin
      st_set[lbc_pkg::ST_CMP] = 1'b1;
    end
    // Set wins over a clear in the same cycle
    s_d.status = (s_q.status & ~st_clr) | st_set;
    // mask enables the interrupt, cleared at reset
    s_d.irq = |(s_q.status & s_q.mask);
  end

  // State register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      s_q         <= '0;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.ctrl    <= lbc_pkg::CTRL_RST;
      s_q.low     <= lbc_pkg::LOW_RST;
      s_q.high    <= HIGH_RST;
      s_q.start   <= lbc_pkg::START_RST;
      s_q.cmp     <= CMP_RST;
      s_q.cmp0    <= lbc_pkg::CMP0_RST;
      s_q.cmp1    <= lbc_pkg::CMP1_RST;
      s_q.count   <= lbc_pkg::START_RST;
      s_q.mask    <= lbc_pkg::MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Ports straight from flops
  assign AWREADY = s_q.awready;
  assign WREADY  = s_q.wready;
  assign BVALID  = s_q.bvalid;
  assign BRESP   = s_q.bresp;
  assign ARREADY = s_q.arready;
  assign RVALID  = s_q.rvalid;
  assign RDATA   = s_q.rdata;
  assign RRESP   = s_q.rresp;
  assign CMP_OUT = s_q.cmp_bit;
  assign IRQ     = s_q.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  property p_low_fixed;
    !SIGNED_RANGE |-> s_q.low == 32'h00000000;
  endproperty
  a_low_fixed: assert property (p_low_fixed)
    else $error("low limit not fixed at zero");

  property p_start_load;
    start_wr |=> s_q.count == s_q.start;
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("start value not loaded");

  property p_step_up;
    cnt_ev && !down && !start_wr && s_q.count != s_q.high
      && !(hw_mode && !s_q.gate)
      |=> s_q.count == $past(s_q.count) + 32'h00000001;
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("count did not step up by one");

  property p_dir_pin;
    cnt_ev && di_sel == lbc_pkg::DI_DIR && aux_lvl && !start_wr
      && s_q.count != s_q.low
      |=> s_q.count == $past(s_q.count) - 32'h00000001;
  endproperty
  a_dir_pin: assert property (p_dir_pin)
    else $error("direction pin high did not count down");

  property p_hold_closed;
    !gate_open && !start_wr |=> $stable(s_q.count);
  endproperty
  a_hold_closed: assert property (p_hold_closed)
    else $error("count moved with gate closed");

  property p_wrap_up;
    cnt_ev && !down && !start_wr && s_q.count == s_q.high && s_q.gate
      |=> s_q.count == $past(s_q.low) && s_q.status[lbc_pkg::ST_LIMIT];
  endproperty
  a_wrap_up: assert property (p_wrap_up)
    else $error("high limit did not load low limit");

  property p_hw_stop;
    cnt_ev && hw_mode && !down && s_q.count == s_q.high && s_q.gate
      && !start_wr |=> s_q.stopped ##1 (s_q.stopped || !s_q.gate);
  endproperty
  a_hw_stop: assert property (p_hw_stop)
    else $error("hardware gate pass did not stop");

  property p_rise_only;
    edge_sel == lbc_pkg::EDGE_RISE && cnt_fall && !start_wr
      && !(hw_mode && gate_open && !s_q.gate) |=> $stable(s_q.count);
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("falling edge counted in rising mode");

  property p_const_out;
    fn_sel == lbc_pkg::FN_OFF1 ##1 fn_sel == lbc_pkg::FN_OFF1 |-> CMP_OUT;
  endproperty
  a_const_out: assert property (p_const_out)
    else $error("compare output not held high");

  property p_cmp_follow;
    fn_sel == lbc_pkg::FN_TO_HI && s_q.count == s_q.cmp |=> CMP_OUT;
  endproperty
  a_cmp_follow: assert property (p_cmp_follow)
    else $error("compare output lags its function");

  property p_irq_gate;
    (s_q.status & s_q.mask) == 2'h0 |=> !IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enabled status");

  c_wrap:  cover property (cnt_ev && s_q.count == s_q.high);
  c_cmp:   cover property (s_q.status[lbc_pkg::ST_CMP] ##1 IRQ);
  c_stop:  cover property (s_q.stopped ##1 !s_q.stopped);
  c_read:  cover property (RVALID && RREADY);

endmodule

// file: lbc_pkg.sv
// Purpose: Shared constants and types of the limited up/down counter.
// Assumes: AXI4-Lite slave with 32-bit data, word-aligned registers.
// Notes:   Offsets are byte addresses; all fields live in the low bits.
package lbc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LOW    = 8'h04;
  localparam logic [7:0] OFS_HIGH   = 8'h08;
  localparam logic [7:0] OFS_START  = 8'h0C;
  localparam logic [7:0] OFS_CMP    = 8'h10;
  localparam logic [7:0] OFS_CMP0   = 8'h14;
  localparam logic [7:0] OFS_CMP1   = 8'h18;
  localparam logic [7:0] OFS_COUNT  = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_MASK   = 8'h24;

  // Control field positions
  localparam int CTRL_SWGATE  = 0;
  localparam int CTRL_EDGE_LS = 1;
  localparam int CTRL_DOWN    = 3;
  localparam int CTRL_FN_LS   = 4;
  localparam int CTRL_DI_LS   = 7;
  localparam int CTRL_STOP    = 9;
  localparam logic [31:0] CTRL_MASK = 32'h000003FF;

  // Status and mask bit positions
  localparam int ST_CMP   = 0;
  localparam int ST_LIMIT = 1;

  // Values after reset
  localparam logic [31:0] CTRL_RST   = 32'h00000000;
  localparam logic [31:0] LOW_RST    = 32'h00000000;
  localparam logic [31:0] HIGH_RST_S = 32'h7FFFFFFF;
  localparam logic [31:0] HIGH_RST_U = 32'hFFFFFFFF;
  localparam logic [31:0] START_RST  = 32'h00000000;
  localparam logic [31:0] CMP_RST_S  = 32'h0000000A;
  localparam logic [31:0] CMP_RST_U  = 32'h00000001;
  localparam logic [31:0] CMP0_RST   = 32'h00000000;
  localparam logic [31:0] CMP1_RST   = 32'h0000000A;
  localparam logic [1:0]  MASK_RST   = 2'h0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h2
  } lbc_edge_t;

  typedef enum logic [2:0] {
    FN_OFF0   = 3'h0,
    FN_OFF1   = 3'h1,
    FN_INSIDE = 3'h2,
    FN_OUTSID = 3'h3,
    FN_TO_HI  = 3'h4,
    FN_TO_LO  = 3'h5
  } lbc_fn_t;

  typedef enum logic [1:0] {
    DI_NONE = 2'h0,
    DI_GATE = 2'h1,
    DI_DIR  = 2'h2
  } lbc_di_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } lbc_sync_t;

endpackage

// file: lbc_sync.sv
// Purpose: Two-flop synchroniser with edge detection for one pin.
// Assumes: Pin is asynchronous to clk.
// Notes:   Stage one feeds stage two only; edges come from later stages.
module lbc_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);

  lbc_pkg::lbc_sync_t s_q;
  lbc_pkg::lbc_sync_t s_d;

  // Next state of the shift chain
  always_comb begin
    s_d    = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  // Chain register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Level and edges from settled stages
  assign lvl  = s_q.s2;
  assign rise = s_q.s2 & ~s_q.s3;
  assign fall = ~s_q.s2 & s_q.s3;

endmodule

// file: lbc_field_model.sv
// Purpose: Process-side model driving the counting and auxiliary pins.
// Assumes: Pins are plain push-pull levels, no pull resistors.
// Notes:   Holds each level for several clocks so edges never merge.
module lbc_field_model (
  input  wire logic clk,
  output logic      cnt_in,
  output logic      aux_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels at time zero
  initial begin
    cnt_in = 1'b0;
    aux_in = 1'b0;
  end

  // Full pulses; hold sets how fast the process runs
  task automatic pulses(input int n, input int hold = 4);
    repeat (n) begin
      @(posedge clk);
      cnt_in <= 1'b1;
      repeat (hold) @(posedge clk);
      cnt_in <= 1'b0;
      repeat (hold - 1) @(posedge clk);
    end
    // Let the synchroniser and count settle
    repeat (6) @(posedge clk);
  endtask

  // Auxiliary level, then time to pass the synchroniser
  task automatic set_aux(input logic v);
    @(posedge clk);
    aux_in <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule

// file: tb_limited_updown_counter_compare.sv
// Purpose: Self-checking bench of the limited up/down counter.
// Assumes: Signed range variant, 10 MHz clock, AXI4-Lite master tasks.
// Notes:   Limits and compare values stay consistent in every scenario.
module tb_limited_updown_counter_compare;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK, SRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, CMP_OUT, IRQ;
  logic        CNT_IN, AUX_IN;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  int          errors, cmp_count;
  logic [31:0] rst_tab [10];
  int          vt [3];

  // Clock of 100 ns period
  initial CLK = 1'b0;
  always #50 CLK = ~CLK;

  lbc_counter #(.SIGNED_RANGE(1'b1)) dut_u (
    .CLK(CLK), .SRST(SRST), .CNT_IN(CNT_IN), .AUX_IN(AUX_IN),
    .CMP_OUT(CMP_OUT), .IRQ(IRQ), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
  );

  lbc_field_model fld_u (.clk(CLK), .cnt_in(CNT_IN), .aux_in(AUX_IN));

  // One comparison, counted
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write; address and data released each at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = lbc_pkg::RESP_OKAY,
                    input logic [3:0] s = 4'hF);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLK);
      if (!aw && AWREADY === 1'b1) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end
    BREADY <= 1'b1;
    do @(posedge CLK); while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, BRESP});
  endtask

  // Read and compare; ck low skips the data check but still checks the response
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = lbc_pkg::RESP_OKAY,
                    input bit ck = 1'b1);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (RVALID !== 1'b1);
    // RREADY stays high; a following read would raise it again at once
    if (ck)
      chk($sformatf("reg_%h", a), e, RDATA);
    chk("rresp", {30'h0, er}, {30'h0, RRESP});
  endtask

  // Expected compare bit for CMP 5, CMP0 3, CMP1 8, LOW 0, HIGH 20
  function automatic logic fexp(int f, int v);
    case (f)
      0: return 1'b0;
      1: return 1'b1;
      2: return v >= 3 && v <= 8;
      3: return !(v >= 3 && v <= 8);
      4: return v >= 5 && v <= 20;
      default: return v <= 5;
    endcase
  endfunction

  // Main sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    SRST <= 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} <= 5'h00;
    WSTRB <= 4'hF;
    AWADDR <= 8'h00;
    ARADDR <= 8'h00;
    WDATA <= 32'h00000000;
    vt = '{2, 5, 10};
    rst_tab = '{lbc_pkg::CTRL_RST, lbc_pkg::LOW_RST, lbc_pkg::HIGH_RST_S,
                lbc_pkg::START_RST, lbc_pkg::CMP_RST_S, lbc_pkg::CMP0_RST,
                lbc_pkg::CMP1_RST, 32'h0, 32'h0, {30'h0, lbc_pkg::MASK_RST}};
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    chk("cmp_out", 32'h0, {31'h0, CMP_OUT});
    chk("irq", 32'h0, {31'h0, IRQ});
    // Reset values of the whole map
    for (int i = 0; i < 10; i++)
      rc(8'(4 * i), rst_tab[i]);
    // Refused accesses leave the count alone
    rc(8'h30, 32'h0, lbc_pkg::RESP_SLVERR);
    wr(lbc_pkg::OFS_COUNT, 32'h5, lbc_pkg::RESP_SLVERR);
    rc(lbc_pkg::OFS_COUNT, 32'h0);
    // In-range limits and compare values for every later step
    wr(lbc_pkg::OFS_HIGH, 32'h14);
    wr(lbc_pkg::OFS_CMP, 32'hFFFFFF05, , 4'h1);
    rc(lbc_pkg::OFS_CMP, 32'h5);
    wr(lbc_pkg::OFS_CMP0, 32'h3);
    wr(lbc_pkg::OFS_CMP1, 32'h8);
    // Each edge selection, each at its own pulse rate
    for (int e = 0; e < 3; e++) begin
      wr(lbc_pkg::OFS_START, 32'h0);
      wr(lbc_pkg::OFS_CTRL, 32'(e * 2 + 1));
      fld_u.pulses(3, 3 + e);
      rc(lbc_pkg::OFS_COUNT, (e == 2) ? 32'h6 : 32'h3);
    end
    // Direction pin high counts down, low counts up
    wr(lbc_pkg::OFS_START, 32'h5);
    wr(lbc_pkg::OFS_CTRL, 32'h101);
    fld_u.set_aux(1'b1);
    fld_u.pulses(2);
    rc(lbc_pkg::OFS_COUNT, 32'h3);
    fld_u.set_aux(1'b0);
    fld_u.pulses(1);
    rc(lbc_pkg::OFS_COUNT, 32'h4);
    // Negative low limit, downward violation loads high limit
    wr(lbc_pkg::OFS_LOW, 32'hFFFFFFFE);
    wr(lbc_pkg::OFS_START, 32'h0);
    wr(lbc_pkg::OFS_CTRL, 32'h9);
    fld_u.pulses(3);
    rc(lbc_pkg::OFS_COUNT, 32'h14);
    rc(lbc_pkg::OFS_STATUS, 32'h2);
    rc(lbc_pkg::OFS_STATUS, 32'h0);
    wr(lbc_pkg::OFS_LOW, 32'h0);
    // Stop on limit: later edges ignored until gate reopens
    wr(lbc_pkg::OFS_START, 32'h13);
    wr(lbc_pkg::OFS_CTRL, 32'h201);
    fld_u.pulses(3);
    rc(lbc_pkg::OFS_COUNT, 32'h0);
    wr(lbc_pkg::OFS_CTRL, 32'h0);
    wr(lbc_pkg::OFS_CTRL, 32'h201);
    fld_u.pulses(1);
    rc(lbc_pkg::OFS_COUNT, 32'h1);
    // Every output function at three counts
    for (int f = 0; f < 6; f++)
      for (int j = 0; j < 3; j++) begin
        wr(lbc_pkg::OFS_CTRL, 32'(f * 16));
        wr(lbc_pkg::OFS_START, 32'(vt[j]));
        repeat (2) @(posedge CLK);
        chk("cmp_out", {31'h0, fexp(f, vt[j])}, {31'h0, CMP_OUT});
      end
    // Compare event interrupt, enabled then masked
    for (int m = 1; m >= 0; m--) begin
      wr(lbc_pkg::OFS_MASK, 32'(m));
      wr(lbc_pkg::OFS_CTRL, 32'h41);
      wr(lbc_pkg::OFS_START, 32'h3);
      rc(lbc_pkg::OFS_STATUS, 32'h0, , 1'b0);
      fld_u.pulses(2);
      chk("irq", 32'(m), {31'h0, IRQ});
      rc(lbc_pkg::OFS_STATUS, 32'h1);
      repeat (2) @(posedge CLK);
      chk("irq", 32'h0, {31'h0, IRQ});
    end
    // Hardware gate needs software gate; one-time count stops at limit
    wr(lbc_pkg::OFS_START, 32'h12);
    wr(lbc_pkg::OFS_CTRL, 32'h80);
    fld_u.set_aux(1'b1);
    fld_u.pulses(2);
    rc(lbc_pkg::OFS_COUNT, 32'h12);
    fld_u.set_aux(1'b0);
    wr(lbc_pkg::OFS_CTRL, 32'h81);
    fld_u.set_aux(1'b1);
    fld_u.pulses(4);
    rc(lbc_pkg::OFS_COUNT, 32'h0);
    final_report;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge CLK);
    errors++;
    final_report;
  end

  // Verdict and end of run
  task final_report;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
endmodule
